// File: rtl/hbc_pkg.sv
// Shared constants and carrier types for the half-bridge output controller.
// Assumes a 32-bit APB slave port and one 200 MHz clock domain.
package hbc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_BRIDGES = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_OUT_SEL = 6'h01;  // bridge_output_select_reg
  localparam logic [5:0] IDX_STAT_CTL = 6'h03; // bridge_status_control_reg
  localparam logic [5:0] IDX_MUX_CTL = 6'h08;  // analog_mux_control_reg
  localparam logic [5:0] IDX_SYS_CTL = 6'h0a;  // system_control_reg
  localparam logic [5:0] IDX_IRQ_FLAG = 6'h0b; // irq_flag_reg
  localparam logic [5:0] IDX_IRQ_MASK = 6'h0c; // irq mask, same layout as flags

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int STAT_RECIRC_BIT = 7;  // recirculation_mode
  localparam int SYS_PSE_BIT = 0;      // power_stage_enable
  localparam int SYS_HTSO_BIT = 1;     // high_temp_shutdown_option
  localparam int SYS_VSI_BIT = 2;      // voltage_shutdown_inhibit
  localparam int IRQ_HT_BIT = 0;       // high_temp_flag
  localparam int IRQ_LV_BIT = 1;       // low_voltage_flag
  localparam int IRQ_HV_BIT = 2;       // high_voltage_flag
  localparam int MUX_GAIN_BIT = 4;     // sense_gain_select
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] SEL_OFF = 2'b00;  // {high, low} select pair
  localparam logic [1:0] SEL_PWM = 2'b11;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } hbc_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } hbc_apb_rsp_t;

  // Analog monitor levels, high while the condition is present
  typedef struct packed {
    logic tempWarn;
    logic tempShutdown;
    logic lowVolt;
    logic highVolt;
  } hbc_monitor_t;

  // Per-bridge feedback from the power stage
  typedef struct packed {
    logic [NUM_BRIDGES-1:0] ocHigh;
    logic [NUM_BRIDGES-1:0] ocLow;
    logic [NUM_BRIDGES-1:0] highOff;
    logic [NUM_BRIDGES-1:0] lowOff;
  } hbc_bridge_fb_t;

  // Gate commands, one bit per bridge
  typedef struct packed {
    logic [NUM_BRIDGES-1:0] high;
    logic [NUM_BRIDGES-1:0] low;
  } hbc_gate_t;

endpackage

// File: rtl/hbc_sync.sv
// Two-flop synchroniser for the asynchronous PWM pin.
// Assumes the caller reads only dout; the first stage feeds nothing else.
`timescale 1ns/1ps
module hbc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import hbc_pkg::*;

  logic [WIDTH-1:0] meta; // First stage, may be metastable

  // Both stages clear on reset; only the second stage is visible
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_sync_delay: assert property (@(posedge mclk) disable iff (srst)
    !$past(srst) && !$past(srst, 2) |-> dout == $past(din, 2))
    else $error("pwm synchroniser delay is not two cycles");

endmodule

// File: rtl/hbc_gate.sv
// Gate driver for one half-bridge with break-before-make interlock.
// Assumes highOff/lowOff report the sensed gate levels, synchronous to mclk.
`timescale 1ns/1ps
module hbc_gate (
  input wire logic mclk,
  input wire logic srst,
  input wire logic wantHigh,
  input wire logic wantLow,
  input wire logic highOff,
  input wire logic lowOff,
  output logic gateHigh,
  output logic gateLow
);
  import hbc_pkg::*;

  // A side turns on only when the opposite gate is sensed off and
  // not commanded on; the feedback check covers gate discharge time
  always_ff @(posedge mclk) begin
    if (srst) begin
      gateHigh <= 1'b0;
      gateLow <= 1'b0;
    end else begin
      gateHigh <= wantHigh && lowOff && !gateLow && !wantLow;
      gateLow <= wantLow && highOff && !gateHigh && !wantHigh;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_overlap: assert property (@(posedge mclk) disable iff (srst)
    !(gateHigh && gateLow))
    else $error("both gates of one bridge are on");

  a_bbm_high: assert property (@(posedge mclk) disable iff (srst)
    $rose(gateHigh) |-> $past(lowOff) && !$past(gateLow))
    else $error("high gate rose before low gate was off");

  a_bbm_low: assert property (@(posedge mclk) disable iff (srst)
    $rose(gateLow) |-> $past(highOff) && !$past(gateHigh))
    else $error("low gate rose before high gate was off");

endmodule

// File: rtl/hbc_top.sv
// Register-controlled driver for four power half-bridges, with PWM,
// recirculation, break-before-make and protection flags over APB.
// Assumes monitor and feedback inputs are synchronous to mclk; only
// the PWM pin is asynchronous and is synchronised here.
//
// Function
// - Power-stage enable gates all bridge switching.
// - Select pair decodes off, low, high, PWM.
// - Never both gates on; both bits mean PWM.
// - Turn-on waits until opposite gate senses off.
// - Reset clears the output select register.
// - PWM mode: high gate follows PWM pin.
// - Recirculation bit drives low gate when high off.
// - Sense gain bit selects current sense resolution.
// - Warning temperature sets flag; mask gates interrupt.
// - Shutdown option turns high-side gates off on warning.
// - Write one clears temp flag unless still hot.
// - Second threshold turns every power stage off while shutdown option is clear.
// - Overcurrent switches that gate off, sets flag.
// - Overcurrent flag clears only by one or reset.
// - Voltage flag disables bridges unless inhibited.
// - Write one clears voltage flags unless present.
// - Status register layout: recirc, zeros, flags.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module hbc_top (
  input wire logic mclk,
  input wire logic srst,
  input wire hbc_pkg::hbc_apb_req_t apbReq,
  output hbc_pkg::hbc_apb_rsp_t apbRsp,
  input wire logic pwmPin,
  input wire hbc_pkg::hbc_monitor_t monitor,
  input wire hbc_pkg::hbc_bridge_fb_t bridgeFb,
  output hbc_pkg::hbc_gate_t gates,
  output logic allPowerOff,
  output logic senseGain,
  output logic [3:0] muxSource,
  output logic irq
);
  import hbc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] outSel;                 // Select pairs, low bit then high bit
  logic recirc;                       // Recirculation mode
  logic [NUM_BRIDGES-1:0] ocFlag;     // Sticky overcurrent flags
  logic [2:0] system_control_reg;                 // Enable, temp option, voltage inhibit
  logic [4:0] muxCtl;                 // Gain bit over source select
  logic [2:0] irqFlag;                // Sticky temp and voltage flags
  logic [2:0] irqMask;                // Interrupt mask, same layout
  logic pready;                       // Access-phase answer
  logic pslverr;                      // Unmapped address answer
  logic [DATA_W-1:0] prdata;          // Registered read data
  logic [7:0] rdByte;                 // Read mux result
  logic hit;                          // Address decodes to a register
  logic wrAcc;                        // Write completes this edge
  logic [5:0] regIdx;                 // Word index from the address
  logic pwmSync;                      // PWM pin in the mclk domain
  logic stageOn;                      // Global enable
  logic htsoOff;                      // Warning-level high-side shutdown
  logic htrOff;                       // Second-threshold shutdown
  logic voltOff;                      // Voltage shutdown
  logic allOff;                       // Any reason to stop every gate
  logic [NUM_BRIDGES-1:0] wantHi;     // Gated high-side request
  logic [NUM_BRIDGES-1:0] wantLo;     // Gated low-side request
  logic [NUM_BRIDGES-1:0] gateHighQ;  // Gate flops, high side
  logic [NUM_BRIDGES-1:0] gateLowQ;   // Gate flops, low side
  logic [NUM_BRIDGES-1:0] ocClr;      // Write-one-to-clear for oc flags
  logic [2:0] irqClr;                 // Write-one-to-clear for irq flags

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // PWM pin synchroniser
  // ----------------------------------------------------------------
  // The raw pin may glitch against mclk; gates only see the retimed copy
  hbc_sync #(.WIDTH(1)) u_pwm_sync (
    .mclk(mclk),
    .srst(srst),
    .din(pwmPin),
    .dout(pwmSync)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign regIdx = apbReq.paddr[ADDR_W-1:2];
  assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite && pready;
  assign ocClr = (wrAcc && hit && regIdx == IDX_STAT_CTL) ? apbReq.pwdata[NUM_BRIDGES-1:0] : '0;
  assign irqClr = (wrAcc && hit && regIdx == IDX_IRQ_FLAG) ? apbReq.pwdata[2:0] : '0;

  // Read mux; unused bits read as zero
  always_comb begin
    hit = (apbReq.paddr[1:0] == 2'b00);
    rdByte = REG_RESET;
    unique case (regIdx)
      IDX_OUT_SEL: rdByte = outSel;
      IDX_STAT_CTL: rdByte = {recirc, 3'b000, ocFlag};
      IDX_MUX_CTL: rdByte = {3'b000, muxCtl};
      IDX_SYS_CTL: rdByte = {5'b00000, system_control_reg};
      IDX_IRQ_FLAG: rdByte = {5'b00000, irqFlag};
      IDX_IRQ_MASK: rdByte = {5'b00000, irqMask};
      default: hit = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (apbReq.psel && apbReq.penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !hit;
      prdata <= (hit && !apbReq.pwrite) ? {24'h000000, rdByte} : '0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
  end

  assign apbRsp = '{prdata: prdata, pready: pready, pslverr: pslverr};

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Plain read/write storage; a bad address writes nothing
  always_ff @(posedge mclk) begin
    if (srst) begin
      outSel <= REG_RESET;
      recirc <= 1'b0;
      system_control_reg <= '0;
      muxCtl <= '0;
      irqMask <= '0;
    end else if (wrAcc && hit) begin
      unique case (regIdx)
        IDX_OUT_SEL: outSel <= apbReq.pwdata[7:0];
        IDX_STAT_CTL: recirc <= apbReq.pwdata[STAT_RECIRC_BIT];
        IDX_MUX_CTL: muxCtl <= apbReq.pwdata[4:0];
        IDX_SYS_CTL: system_control_reg <= apbReq.pwdata[2:0];
        IDX_IRQ_MASK: irqMask <= apbReq.pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Sense amplifier setting goes straight out to the analog side
  assign senseGain = muxCtl[MUX_GAIN_BIT];
  assign muxSource = muxCtl[3:0];

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  // Set wins over clear, so a clear while the event persists is ignored
  always_ff @(posedge mclk) begin
    if (srst) begin
      ocFlag <= '0;
    end else begin
      ocFlag <= (ocFlag & ~ocClr) | bridgeFb.ocHigh | bridgeFb.ocLow;
    end
  end

  // Levels from the monitors keep their flags set while present
  always_ff @(posedge mclk) begin
    if (srst) begin
      irqFlag <= '0;
    end else begin
      irqFlag[IRQ_HT_BIT] <= (irqFlag[IRQ_HT_BIT] && !irqClr[IRQ_HT_BIT]) || monitor.tempWarn;
      irqFlag[IRQ_LV_BIT] <= (irqFlag[IRQ_LV_BIT] && !irqClr[IRQ_LV_BIT]) || monitor.lowVolt;
      irqFlag[IRQ_HV_BIT] <= (irqFlag[IRQ_HV_BIT] && !irqClr[IRQ_HV_BIT]) || monitor.highVolt;
    end
  end

  // Level interrupt, one cycle behind the flags
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqFlag & irqMask);
    end
  end

  // ----------------------------------------------------------------
  // Protection and enables
  // ----------------------------------------------------------------
  assign stageOn = system_control_reg[SYS_PSE_BIT];
  assign htsoOff = irqFlag[IRQ_HT_BIT] && system_control_reg[SYS_HTSO_BIT];
  assign htrOff = monitor.tempShutdown && !system_control_reg[SYS_HTSO_BIT];
  assign voltOff = (irqFlag[IRQ_LV_BIT] || irqFlag[IRQ_HV_BIT]) && !system_control_reg[SYS_VSI_BIT];
  assign allOff = !stageOn || htrOff || voltOff;

  // Tells the other power stages to drop out as well
  always_ff @(posedge mclk) begin
    if (srst) begin
      allPowerOff <= 1'b1;
    end else begin
      allPowerOff <= allOff || htrOff;
    end
  end

  // ----------------------------------------------------------------
  // Per-bridge decode and gate drivers
  // ----------------------------------------------------------------
  // A flagged bridge stays dark until software clears its flag; the live
  // overcurrent input also drops its own gate in the same edge
  for (genvar i = 0; i < NUM_BRIDGES; i++) begin : g_bridge
    logic selLo;
    logic selHi;
    logic pwmMode;
    logic reqHi;
    logic reqLo;
    assign selLo = outSel[2*i];
    assign selHi = outSel[2*i+1];
    assign pwmMode = selLo && selHi;
    assign reqHi = pwmMode ? pwmSync : (selHi && !selLo);
    assign reqLo = pwmMode ? (recirc && !pwmSync) : (selLo && !selHi);
    assign wantHi[i] = reqHi && !allOff && !htsoOff && !ocFlag[i] && !bridgeFb.ocHigh[i];
    assign wantLo[i] = reqLo && !allOff && !ocFlag[i] && !bridgeFb.ocLow[i];

    hbc_gate u_gate (
      .mclk(mclk),
      .srst(srst),
      .wantHigh(wantHi[i]),
      .wantLow(wantLo[i]),
      .highOff(bridgeFb.highOff[i]),
      .lowOff(bridgeFb.lowOff[i]),
      .gateHigh(gateHighQ[i]),
      .gateLow(gateLowQ[i])
    );
  end

  assign gates = '{high: gateHighQ, low: gateLowQ};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_stage_gate: assert property (!stageOn |=> gateHighQ == '0 && gateLowQ == '0)
    else $error("gate on while power stage disabled");

  a_decode_off: assert property (outSel[1:0] == SEL_OFF |=> !gateHighQ[0] && !gateLowQ[0])
    else $error("bridge 0 gate on with select pair clear");

  a_reset_clear: assert property ($past(srst) |-> outSel == REG_RESET && !recirc && ocFlag == '0)
    else $error("select or status not cleared by reset");

  a_pwm_follow: assert property (outSel[1:0] == SEL_PWM && !allOff && !htsoOff && !ocFlag[0]
    && !bridgeFb.ocHigh[0] && bridgeFb.lowOff[0] && !gateLowQ[0] |=> gateHighQ[0] == $past(pwmSync))
    else $error("bridge 0 high gate does not follow pwm");

  a_recirc_low: assert property (outSel[1:0] == SEL_PWM && !recirc |=> !gateLowQ[0])
    else $error("low gate on in pwm without recirculation");

  a_gain_write: assert property (wrAcc && hit && regIdx == IDX_MUX_CTL
    |=> senseGain == $past(apbReq.pwdata[MUX_GAIN_BIT]))
    else $error("sense gain did not take written value");

  a_ht_flag: assert property (monitor.tempWarn |=> irqFlag[IRQ_HT_BIT] ##1
    (irq == irqMask[IRQ_HT_BIT] || $past(irqMask[IRQ_HT_BIT]) != irqMask[IRQ_HT_BIT] || irq))
    else $error("high temperature flag not set");

  a_ht_shut: assert property (htsoOff |=> gateHighQ == '0)
    else $error("high gate on during warning shutdown");

  a_htr_off: assert property (htrOff |=> gateHighQ == '0 && gateLowQ == '0 && allPowerOff)
    else $error("stage on beyond second threshold");

  a_oc_set: assert property (bridgeFb.ocHigh[0] |=> ocFlag[0] && !gateHighQ[0] ##1 !gateHighQ[0])
    else $error("overcurrent did not switch off and flag");

  a_oc_hold: assert property (ocFlag[0] && !ocClr[0] |=> ocFlag[0])
    else $error("overcurrent flag lost without a one write");

  a_volt_off: assert property (voltOff |=> gateHighQ == '0 && gateLowQ == '0)
    else $error("bridge on during voltage shutdown");

  a_volt_keep: assert property (monitor.lowVolt && irqClr[IRQ_LV_BIT] |=> irqFlag[IRQ_LV_BIT])
    else $error("low voltage flag cleared while condition present");

  a_stat_zero: assert property (pready && !apbReq.pwrite && regIdx == IDX_STAT_CTL
    |-> prdata[6:4] == 3'b000)
    else $error("status reserved bits read nonzero");

  a_apb_ready: assert property (apbReq.psel && apbReq.penable && !pready |=> pready)
    else $error("apb answer not one cycle after access");

  c_pwm_recirc: cover property (outSel[1:0] == SEL_PWM && recirc && gateLowQ[0] ##[1:40] gateHighQ[0]);
  c_oc_clear: cover property (ocFlag[0] ##1 !ocFlag[0]);
  c_ht_shutdown: cover property (htsoOff && irq);
  c_volt_shutdown: cover property (voltOff ##1 !voltOff);

endmodule

// File: tb/hbc_power_stage.sv
// Behavioural power stage: gate-level feedback and injectable shorts.
// Assumes gate commands come from flops in the mclk domain.
`timescale 1ns/1ps
module hbc_power_stage
  import hbc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire hbc_pkg::hbc_gate_t gates,
  input wire hbc_pkg::hbc_gate_t shortCmd,
  input wire logic slow,
  output hbc_pkg::hbc_bridge_fb_t bridgeFb
);
  // ----------------------------------------------------------------
  // Gate discharge delay
  // ----------------------------------------------------------------
  hbc_gate_t pipe1; // Gate level one cycle back
  hbc_gate_t pipe2; // Two cycles back
  hbc_gate_t pipe3; // Three cycles back, slow discharge
  hbc_gate_t sensed; // Level the sense comparator sees

  // Shift gate levels so turn-off is reported late, never early
  always_ff @(posedge mclk) begin
    if (srst) begin
      pipe1 <= '0;
      pipe2 <= '0;
      pipe3 <= '0;
    end else begin
      pipe1 <= gates;
      pipe2 <= pipe1;
      pipe3 <= pipe2;
    end
  end

  // Slow mode stretches discharge to stress the interlock
  assign sensed = slow ? pipe3 : pipe1;
  // A gate reads on as soon as commanded and off only after decay
  assign bridgeFb.highOff = ~(sensed.high | gates.high);
  assign bridgeFb.lowOff = ~(sensed.low | gates.low);
  // A short only draws current through a conducting device
  assign bridgeFb.ocHigh = shortCmd.high & gates.high;
  assign bridgeFb.ocLow = shortCmd.low & gates.low;
endmodule

// File: tb/hbc_top_test.sv
// Self-checking bench for the half-bridge controller over APB.
// Assumes one 200 MHz clock and the power-stage model beside it.
`timescale 1ns/1ps
module hbc_top_test;
  import hbc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0; // Bench clock
  logic srst; // Synchronous reset
  hbc_apb_req_t apbReq; // Bus request
  hbc_apb_rsp_t apbRsp; // Bus answer
  logic pwmPin; // PWM pin, async to the block
  hbc_monitor_t monitor; // Analog monitor levels
  hbc_bridge_fb_t bridgeFb; // Power-stage feedback
  hbc_gate_t gates; // Gate commands
  hbc_gate_t shortCmd; // Injected shorts
  hbc_gate_t hPrev; // Gates one edge back
  hbc_bridge_fb_t fbPrev; // Feedback one edge back
  logic slow; // Slow gate discharge
  logic allPowerOff; // Global stage off
  logic senseGain; // Sense resolution
  logic [3:0] muxSource; // Mux source
  logic irq; // Interrupt level
  logic [31:0] rd; // Read data
  logic err; // Slave error
  logic [7:0] sel; // Random select byte
  logic recirc; // Random recirculation bit
  int seed; // Random seed
  int bad_count = 0; // Mismatches
  int checks = 0; // Comparisons made

  always #2.5 mclk = ~mclk;

  hbc_top DUT (.mclk(mclk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp), .pwmPin(pwmPin),
    .monitor(monitor), .bridgeFb(bridgeFb), .gates(gates), .allPowerOff(allPowerOff),
    .senseGain(senseGain), .muxSource(muxSource), .irq(irq));
  hbc_power_stage stage (.mclk(mclk), .srst(srst), .gates(gates), .shortCmd(shortCmd),
    .slow(slow), .bridgeFb(bridgeFb));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 40);
    if (n >= 40) bad_count++;
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Expected gates from select byte, PWM level and recirculation
  function automatic logic [7:0] expGates(input logic [7:0] s, input logic p, input logic r);
    hbc_gate_t g;
    for (int i = 0; i < NUM_BRIDGES; i++) begin
      g.high[i] = (s[2*i+:2] == 2'b10) || (s[2*i+:2] == SEL_PWM && p);
      g.low[i] = (s[2*i+:2] == 2'b01) || (s[2*i+:2] == SEL_PWM && !p && r);
    end
    return g;
  endfunction

  task automatic summarize();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Interlock watch: never both on, turn-on only after opposite sensed off
  always @(posedge mclk) begin
    hPrev <= gates;
    fbPrev <= bridgeFb;
    if (srst === 1'b0) begin
      check(32'(gates.high & gates.low), 32'h0);
      check(32'(gates.high & ~hPrev.high & ~fbPrev.lowOff), 32'h0);
      check(32'(gates.low & ~hPrev.low & ~fbPrev.highOff), 32'h0);
    end
  end

  // Hang guard
  initial begin
    #300000;
    bad_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hbb2b;
    srst = 1'b1;
    apbReq = '0;
    pwmPin = 1'b0;
    monitor = '0;
    shortCmd = '0;
    slow = 1'b0;
    tick(3);
    srst <= 1'b0;
    tick(1);
    check(32'(allPowerOff), 32'h1);
    apb(1'b0, IDX_OUT_SEL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, IDX_STAT_CTL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 6'h02, 32'h0);
    check({rd[30:0], err}, 32'h1);
    // Selections while the stage is disabled stay dark
    apb(1'b1, IDX_OUT_SEL, 32'h66);
    tick(8);
    check(32'(gates), 32'h0);
    apb(1'b1, IDX_SYS_CTL, 32'h1);
    // Random select pairs, PWM level and recirculation
    for (int k = 0; k < 16; k++) begin
      sel = (k == 0) ? 8'hff : ((k == 1) ? 8'h99 : 8'($random(seed)));
      recirc = 1'($random(seed));
      slow <= k[0];
      pwmPin <= 1'($random(seed));
      apb(1'b1, IDX_STAT_CTL, {24'h0, recirc, 7'h0});
      apb(1'b1, IDX_OUT_SEL, {24'h0, sel});
      tick(14);
      check(32'(gates), 32'(expGates(sel, pwmPin, recirc)));
      apb(1'b0, IDX_OUT_SEL, 32'h0);
      check(rd, {24'h0, sel});
    end
    apb(1'b1, IDX_STAT_CTL, 32'hff);
    apb(1'b0, IDX_STAT_CTL, 32'h0);
    check(rd, 32'h80);
    apb(1'b1, IDX_MUX_CTL, 32'h1a);
    check({senseGain, muxSource}, 32'h1a);
    apb(1'b1, IDX_MUX_CTL, 32'h05);
    check({senseGain, muxSource}, 32'h05);
    // Shorts on bridge 0 high side and bridge 1 low side
    apb(1'b1, IDX_STAT_CTL, 32'h0);
    apb(1'b1, IDX_OUT_SEL, 32'h06);
    tick(8);
    check(32'(gates), 32'h12);
    shortCmd <= 8'h12;
    tick(1);
    shortCmd <= '0;
    tick(4);
    check(32'(gates), 32'h0);
    check(32'(irq), 32'h0);
    apb(1'b1, IDX_STAT_CTL, 32'h0);
    apb(1'b0, IDX_STAT_CTL, 32'h0);
    check(rd, 32'h03);
    apb(1'b1, IDX_STAT_CTL, 32'h03);
    tick(8);
    check(32'(gates), 32'h12);
    // Warning temperature, mask and clear while still hot
    monitor.tempWarn <= 1'b1;
    tick(3);
    check(32'(irq), 32'h0);
    apb(1'b1, IDX_IRQ_MASK, 32'h1);
    tick(2);
    check(32'(irq), 32'h1);
    apb(1'b1, IDX_IRQ_FLAG, 32'h1);
    apb(1'b0, IDX_IRQ_FLAG, 32'h0);
    check(rd, 32'h1);
    check(32'(gates), 32'h12);
    monitor.tempWarn <= 1'b0;
    apb(1'b1, IDX_IRQ_FLAG, 32'h1);
    tick(2);
    check(32'(irq), 32'h0);
    // Warning shutdown option takes the high sides down
    apb(1'b1, IDX_SYS_CTL, 32'h3);
    monitor.tempWarn <= 1'b1;
    tick(4);
    check(32'(gates.high), 32'h0);
    monitor.tempWarn <= 1'b0;
    apb(1'b1, IDX_IRQ_FLAG, 32'h1);
    tick(8);
    check(32'(gates), 32'h12);
    apb(1'b1, IDX_SYS_CTL, 32'h1);
    monitor.tempShutdown <= 1'b1;
    tick(4);
    check({gates, allPowerOff}, 32'h1);
    monitor.tempShutdown <= 1'b0;
    tick(8);
    check({gates, allPowerOff}, 32'h24);
    // Low then high voltage: shutdown, inhibit, clear refused while present
    for (int j = 0; j < 2; j++) begin
      monitor <= (j == 0) ? 4'b0010 : 4'b0001;
      tick(4);
      check(32'(gates), 32'h0);
      apb(1'b1, IDX_SYS_CTL, 32'h5);
      tick(8);
      check(32'(gates), 32'h12);
      apb(1'b1, IDX_SYS_CTL, 32'h1);
      apb(1'b1, IDX_IRQ_FLAG, 32'h6);
      apb(1'b0, IDX_IRQ_FLAG, 32'h0);
      check(rd, (j == 0) ? 32'h2 : 32'h4);
      monitor <= '0;
      apb(1'b1, IDX_IRQ_FLAG, 32'h6);
      tick(8);
      check(32'(gates), 32'h12);
    end
    summarize();
  end
endmodule
